// ==== testbench/sbclk_board.sv ====
// board side: fitted pull on the secondary speed line
`timescale 1ns/1ns
`default_nettype none
module sbclk_board (
  input  wire logic pull_up_i,
  input  wire logic drive_low_i,
  output logic      line_o
);
  // open drain: only the bridge's pull-down overrides the fitted resistor
  assign line_o = drive_low_i ? 1'b0 : pull_up_i;
endmodule : sbclk_board
`default_nettype wire

// ==== testbench/sbclk_props.sv ====
// checker for speed line, strap and secondary clock behaviour
`timescale 1ns/1ns
`default_nettype none
module sbclk_props (
  input wire logic clk_i, rst_i, wb_ack_o, pm_clock_stop_strap_i, fast_capability_strap_i,
  input wire logic primary_speed_sense_i, secondary_speed_sense_i, secondary_speed_sense_o,
  input wire logic secondary_speed_sense_oe_o, sec_clk_enable_o, fast_mode_o,
  input wire logic [sbclk_pkg::NUM_SEC_CLK-1:0] sec_clk_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // six samples cover two sync flops plus the output register
  wire logic fast_ok = primary_speed_sense_i && fast_capability_strap_i;
  // reset term keeps attempts begun in reset from judging the refill of the sync flops
  a_pull_line_low: assert property ((!primary_speed_sense_i && !rst_i) [*6] |-> secondary_speed_sense_oe_o)
    else $error("line not pulled low");
  a_line_released: assert property ((fast_ok && !rst_i) [*6] |-> !secondary_speed_sense_oe_o)
    else $error("line not released");
  a_never_high: assert property (secondary_speed_sense_oe_o |-> !secondary_speed_sense_o)
    else $error("line driven high");
  a_slow_only: assert property ((!fast_capability_strap_i && !rst_i) [*6]
    |-> !fast_mode_o && secondary_speed_sense_oe_o)
    else $error("fast without strap");
  a_stopped_low: assert property (!sec_clk_enable_o [*2] |-> sec_clk_o == '0)
    else $error("stopped clock not low");
  a_keep_running: assert property ((!pm_clock_stop_strap_i && !rst_i) [*6] |-> sec_clk_enable_o)
    else $error("clocks stopped");
  a_halve_toggle: assert property ((fast_ok && !secondary_speed_sense_i && sec_clk_enable_o && !rst_i) [*6]
    |-> sec_clk_o != $past(sec_clk_o)) else $error("clock not halved");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule : sbclk_props
bind sbclk_top sbclk_props u_props (.*);
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the secondary clock and speed strap block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, pm_clock_stop_strap_i = 0, pull = 1;
  logic fast_capability_strap_i = 1, primary_speed_sense_i = 1, general_pin_three_i = 0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic secondary_speed_sense_i, secondary_speed_sense_o, secondary_speed_sense_oe_o;
  logic sec_clk_enable_o, ejector_switch_in_o, fast_mode_o;
  logic [sbclk_pkg::NUM_SEC_CLK-1:0] sec_clk_o, c0;
  int bad_count = 0, checked = 0, cycles = 0;
  sbclk_top dut (.*);
  sbclk_board board (.pull_up_i(pull), .drive_low_i(secondary_speed_sense_oe_o && !secondary_speed_sense_o),
    .line_o(secondary_speed_sense_i));
  always #4 clk_i = ~clk_i;
  task automatic chk(string n, logic [31:0] e, g);
    checked++;
    bad_count += (g !== e);
    if (g !== e)
      $display("MISMATCH %s expected %h seen %h", n, e, g);
  endtask : chk
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++n < 20);
    if (wb_ack_o !== 1'b1)
      begin
        bad_count++;
        $display("MISMATCH ack expected 1 seen %b", wb_ack_o);
      end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask : settle
  task automatic t_speed;
    for (int i = 0; i < 8; i++)
      begin
        {primary_speed_sense_i, fast_capability_strap_i, pull} <= i[2:0];
        settle();
        chk("pull", !(i[2] && i[1]), secondary_speed_sense_oe_o);
        chk("fast", i[2] && i[1], fast_mode_o);
        c0 = sec_clk_o;
        @(posedge clk_i);
        chk("halve", i[2:0] == 3'b110, sec_clk_o != c0);
      end
  endtask : t_speed
  task automatic t_power;
    for (int p = 0; p < 2; p++)
      begin
        pm_clock_stop_strap_i <= p[0];
        wb(1'b1, sbclk_pkg::REG_CTRL, 32'h0000_0001);
        settle();
        chk("clk en", !p[0], sec_clk_enable_o);
        chk("clk lvl", p[0] ? '0 : {sbclk_pkg::NUM_SEC_CLK{1'b1}}, sec_clk_o);
        wb(1'b1, sbclk_pkg::REG_CTRL, 32'h0000_0000);
        settle();
        chk("clk back", 1, sec_clk_enable_o);
      end
  endtask : t_power
  task automatic t_eject;
    wb(1'b0, sbclk_pkg::REG_CTRL, 32'h0000_0000);
    chk("ctrl", sbclk_pkg::CTRL_RESET, q);
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", 0, q);
    general_pin_three_i <= 1'b1;
    settle();
    chk("eject off", 0, ejector_switch_in_o);
    wb(1'b1, sbclk_pkg::REG_CTRL, 32'h0000_0002);
    settle();
    chk("eject", 1, ejector_switch_in_o);
  endtask : t_eject
  task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (checked > 0 && bad_count == 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial
    begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_eject();
      t_speed();
      t_power();
      stop_test();
    end
  always @(posedge clk_i)
    begin
      cycles <= cycles + 1;
      bad_count <= bad_count + (cycles == 3000);
      if (cycles == 3001)
        stop_test();
    end
endmodule : testbench
`default_nettype wire

// ==== verilog/sbclk_pkg.sv ====
// package for secondary bus clock and speed strap control
package sbclk_pkg;

  // wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // control register fields
  localparam int CTRL_D3_BIT      = 0;
  localparam int CTRL_HOTSWAP_BIT = 1;

  // status register fields
  localparam int ST_CLK_STOP_BIT = 0;
  localparam int ST_FAST_OK_BIT  = 1;
  localparam int ST_SEC_FAST_BIT = 2;
  localparam int ST_HALVE_BIT    = 3;
  localparam int ST_EJECT_BIT    = 4;
  localparam int ST_DRIVE_LO_BIT = 5;
  localparam int ST_PRI_FAST_BIT = 6;
  localparam int ST_GPIN3_BIT    = 7;

  localparam int          NUM_SEC_CLK  = 10;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  // synchronised strap and pin levels
  typedef struct packed {
    logic pm_clock_stop_strap;
    logic fast_capability_strap;
    logic primary_speed_sense;
    logic secondary_speed_sense;
    logic general_pin_three;
  } sbclk_pins_t;

  typedef struct packed {
    sbclk_pins_t                   sync1;
    sbclk_pins_t                   sync2;
    logic [31:0]                   ctrl;
    logic [31:0]                   rdat;
    logic                          ack;
    logic                          clk_stop;
    logic                          halve_phase;
    logic [NUM_SEC_CLK-1:0]        sec_clk;
    logic                          sec_en;
    logic                          speed_oe;
    logic                          ejector;
    logic                          fast_mode;
  } sbclk_state_t;

endpackage : sbclk_pkg

// ==== verilog/sbclk_top.sv ====
// secondary bus clock gating, speed sensing and strap handling
// Functional notes
// [RL1] pm strap high plus D3 parks bus B2
// [RL2] B2 entry stops secondary clocks at 0
// [RL3] pm strap low leaves clocks running
// [RL4] 66 MHz only with capability strap high
// [RL5] primary sense low drives secondary low
// [RL6] primary high: secondary sense is input; here only with capability strap high, else pulled low
// [RL7] secondary sense open drain, never high
// [RL8] hot-swap: general pin three is ejector
// [RL9] 66/33 case: halve primary clock
// [RL10] never secondary faster than primary
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module sbclk_top (
  // clock and reset
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  // wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  // straps and pins
  input  wire logic                            pm_clock_stop_strap_i,
  input  wire logic                            fast_capability_strap_i,
  input  wire logic                            primary_speed_sense_i,
  input  wire logic                            secondary_speed_sense_i,
  input  wire logic                            general_pin_three_i,
  // outputs
  output logic                                 secondary_speed_sense_o,
  output logic                                 secondary_speed_sense_oe_o,
  output logic [sbclk_pkg::NUM_SEC_CLK-1:0]    sec_clk_o,
  output logic                                 sec_clk_enable_o,
  output logic                                 ejector_switch_in_o,
  output logic                                 fast_mode_o
);

  sbclk_pkg::sbclk_state_t st_r;
  sbclk_pkg::sbclk_state_t st_nxt;

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    return r;
  endfunction : merge_sel

  logic        d3_req;
  logic        hotswap;
  logic        pri_fast;
  logic        sec_fast;
  logic        halve;
  logic        req;
  logic [31:0] status;

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.sync1 = {pm_clock_stop_strap_i, fast_capability_strap_i, primary_speed_sense_i,
                    secondary_speed_sense_i, general_pin_three_i};
    st_nxt.sync2 = st_r.sync1;

    d3_req  = st_r.ctrl[sbclk_pkg::CTRL_D3_BIT];
    hotswap = st_r.ctrl[sbclk_pkg::CTRL_HOTSWAP_BIT];
    // a primary sense is only honoured when the part is fast capable
    pri_fast = st_r.sync2.primary_speed_sense & st_r.sync2.fast_capability_strap; // RL4
    // secondary fast needs fast primary too, so no 33/66 combination
    sec_fast = pri_fast & st_r.sync2.secondary_speed_sense; // RL6 RL10
    halve    = pri_fast & ~sec_fast; // RL9

    st_nxt.fast_mode = pri_fast; // RL4
    // open drain: output level is always 0, only the enable moves
    st_nxt.speed_oe = ~st_r.sync2.primary_speed_sense | ~st_r.sync2.fast_capability_strap; // RL5 RL7 RL10

    st_nxt.clk_stop = d3_req & st_r.sync2.pm_clock_stop_strap; // RL1 RL3
    st_nxt.sec_en   = ~st_nxt.clk_stop;

    st_nxt.halve_phase = halve ? ~st_r.halve_phase : 1'b0; // RL9
    if (st_r.clk_stop)
      st_nxt.sec_clk = '0; // RL2
    else
      st_nxt.sec_clk = {sbclk_pkg::NUM_SEC_CLK{halve ? st_r.halve_phase : 1'b1}};

    st_nxt.ejector = hotswap & st_r.sync2.general_pin_three; // RL8

    status = '0;
    status[sbclk_pkg::ST_CLK_STOP_BIT] = st_r.clk_stop;
    status[sbclk_pkg::ST_FAST_OK_BIT]  = st_r.sync2.fast_capability_strap;
    status[sbclk_pkg::ST_SEC_FAST_BIT] = sec_fast;
    status[sbclk_pkg::ST_HALVE_BIT]    = halve;
    status[sbclk_pkg::ST_EJECT_BIT]    = st_r.ejector;
    status[sbclk_pkg::ST_DRIVE_LO_BIT] = st_r.speed_oe;
    status[sbclk_pkg::ST_PRI_FAST_BIT] = pri_fast;
    status[sbclk_pkg::ST_GPIN3_BIT]    = st_r.sync2.general_pin_three;

    req        = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.ack = req;
    st_nxt.rdat = '0;
    if (req)
    begin
      case (wb_adr_i)
        sbclk_pkg::REG_CTRL:
        begin
          st_nxt.rdat = st_r.ctrl;
          if (wb_we_i)
            st_nxt.ctrl = merge_sel(st_r.ctrl, wb_dat_i, wb_sel_i);
        end
        sbclk_pkg::REG_STATUS:
          st_nxt.rdat = status;
        default:
          st_nxt.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r      <= '0;
      st_r.ctrl <= sbclk_pkg::CTRL_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // the clock outputs are registered levels; without halving they stay high unless stopped (then 0),
  // real clock forwarding uses a gated buffer outside this logic
  assign wb_dat_o                   = st_r.rdat;
  assign wb_ack_o                   = st_r.ack;
  assign secondary_speed_sense_o    = 1'b0; // RL7
  assign secondary_speed_sense_oe_o = st_r.speed_oe;
  assign sec_clk_o                  = st_r.sec_clk;
  assign sec_clk_enable_o           = st_r.sec_en;
  assign ejector_switch_in_o        = st_r.ejector;
  assign fast_mode_o                = st_r.fast_mode;

endmodule : sbclk_top
`default_nettype wire
